/* i2h_master.sv */
`timescale 1ns/1ps

module i2h_master
   import i2h_pkg::*;
(
   input  wire logic       sys_clk,       // system clock, 125 MHz
   input  wire logic       resetn,        // asynchronous reset, active low
   input  wire logic       fast_mode,     // 1: 400 kbit/s timing, 0: 100 kbit/s
   input  wire logic [1:0] dev_addr_sel,  // slave_addr_bit_high/low as strapped on device
   input  wire logic       cmd_valid,     // request a transfer
   output logic            cmd_ready,     // idle and able to take a request
   input  wire logic       cmd_is_read,   // 1: read only, 0: command write
   input  wire logic [7:0] cmd_code,      // command code byte
   input  wire logic       cmd_has_param, // send a parameter byte after the code
   input  wire logic [7:0] cmd_param,     // parameter byte
   input  wire logic       cmd_rd_after,  // repeated start and one read after the write
   input  wire logic [7:0] cmd_rd_len,    // bytes to read in a read-only transfer
   output logic            rsp_valid,     // one-cycle pulse: transfer finished
   output logic            rsp_nack,      // device refused a byte of this transfer
   output logic [7:0]      rsp_data,      // last byte read
   output logic            busy,          // transfer in progress
   input  wire logic       scl_in,        // serial clock as seen on the wire
   output logic            scl_out,       // serial clock drive value, always low
   output logic            scl_oe_n,      // low while pulling the clock low
   input  wire logic       sda_in,        // serial data as seen on the wire
   output logic            sda_out,       // serial data drive value, always low
   output logic            sda_oe_n       // low while pulling data low
);

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   // address byte for the given direction
   function automatic logic [7:0] addr_byte(input logic [1:0] sel, input logic dir);
      addr_byte = {DEV_ADDR_UPPER, sel, dir};
   endfunction : addr_byte

   // open-drain enable for a bit slot: low means pull the line low
   function automatic logic slot_oe_n(input logic [3:0] bit_no, input logic [7:0] shf,
                                      input logic rd, input logic last);
      if (bit_no == ACK_SLOT)
         slot_oe_n = rd ? last : 1'b1;
      else
         slot_oe_n = rd ? 1'b1 : shf[7];
   endfunction : slot_oe_n

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: the first stage feeds only the second
   logic scl_m_q;     // clock, first stage
   logic scl_s_q;     // clock, synchronised
   logic sda_m_q;     // data, first stage
   logic sda_s_q;     // data, synchronised

   // both pins shift through their two stages together; reset reads an idle bus
   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn)
         {scl_s_q, scl_m_q, sda_s_q, sda_m_q} <= 4'hF;
      else
         {scl_s_q, scl_m_q, sda_s_q, sda_m_q} <= {scl_m_q, scl_in, sda_m_q, sda_in};

   ////////////////////////////////////////////////////////////////////////////////
   // transfer sequencer
   i2h_state_type state_q, state_d;       // phase of the transfer
   logic [1:0]    qtr_q, qtr_d;           // quarter within a phase
   logic [8:0]    tmr_q, tmr_d;           // quarter countdown
   logic [3:0]    bit_q, bit_d;           // slot within a byte, 8 = ack
   logic [7:0]    shf_q, shf_d;           // shift register
   logic [2:0]    stg_q, stg_d;           // which byte of the transfer
   logic [7:0]    rem_q, rem_d;           // read bytes still to come
   logic [7:0]    par_q, par_d;           // latched parameter
   logic [7:0]    cmd_code_q, cmd_code_d; // latched command code
   logic          hasp_q, hasp_d;         // parameter follows code
   logic          rdaft_q, rdaft_d;       // read back after write
   logic          fast_q, fast_d;         // latched rate
   logic [1:0]    sel_q, sel_d;           // latched address straps
   logic          ack_ok_q, ack_ok_d;     // ack seen in this byte's slot
   logic          scl_oe_n_q, scl_oe_n_d, sda_oe_n_q, sda_oe_n_d; // line pulls
   logic          ready_q, ready_d, busy_q, busy_d;               // command port state
   logic          rsp_valid_q, rsp_valid_d, nack_q, nack_d;       // end pulse, refusal
   logic [7:0]    data_q, data_d;         // last byte read
   logic          drive_low_q;            // pin drive value, always low
   logic [8:0]    qlen;                   // current quarter length
   logic          tick;                   // quarter has elapsed
   logic          rd_byte;                // current byte is read by us

   // next-value logic
   always_comb
   begin
      state_d     = state_q;
      {qtr_d, tmr_d, bit_d, shf_d, stg_d, rem_d, par_d, cmd_code_d, hasp_d, rdaft_d, fast_d,
       sel_d, ack_ok_d, scl_oe_n_d, sda_oe_n_d, ready_d, busy_d, nack_d, data_d} =
         {qtr_q, tmr_q, bit_q, shf_q, stg_q, rem_q, par_q, cmd_code_q, hasp_q, rdaft_q, fast_q,
          sel_q, ack_ok_q, scl_oe_n_q, sda_oe_n_q, ready_q, busy_q, nack_q, data_q};
      rsp_valid_d = 1'b0;
      qlen        = fast_q ? QTR_FAST_CYC : QTR_STD_CYC;
      rd_byte     = (stg_q == STG_READ);
      // a released clock may be held low by the far end; wait for it high
      tick        = (tmr_q == 9'h000) && (qtr_q != 2'h1 || scl_s_q);
      // each elapsed quarter of a running phase reloads the countdown and steps on
      if (tmr_q != 9'h000)
         tmr_d = tmr_q - 9'h001;
      else if (tick && state_q != ST_IDLE)
      begin
         tmr_d = qlen;
         qtr_d = qtr_q + 2'h1;
      end

      unique case (state_q)
         ST_IDLE:
         begin
            // only a fully released bus may be claimed
            if (cmd_valid && ready_q && scl_s_q && sda_s_q)
            begin
               state_d  = ST_START;
               qtr_d    = 2'h0;
               tmr_d    = fast_mode ? QTR_FAST_CYC : QTR_STD_CYC;
               fast_d   = fast_mode;
               sel_d    = dev_addr_sel;
               par_d    = cmd_param;
               cmd_code_d = cmd_code;
               hasp_d   = cmd_has_param;
               rdaft_d  = cmd_rd_after && !cmd_is_read;
               stg_d    = cmd_is_read ? STG_ADDR_RD : STG_ADDR_WR;
               shf_d    = cmd_is_read ? addr_byte(dev_addr_sel, DIR_READ)
                                      : addr_byte(dev_addr_sel, DIR_WRITE);
               rem_d    = (!cmd_is_read || cmd_rd_len == 8'h00) ? 8'h01 : cmd_rd_len;
               ready_d  = 1'b0;
               busy_d   = 1'b1;
               nack_d   = 1'b0;
            end
         end
         ST_START:
            // same sequence for START and repeated START
            if (tick)
               unique case (qtr_q)
                  2'h0: scl_oe_n_d = 1'b1;    // release clock, data already high
                  2'h1: sda_oe_n_d = 1'b0;    // data falls while clock high
                  2'h2: scl_oe_n_d = 1'b0;    // clock low, bits may follow
                  2'h3:
                  begin
                     state_d    = ST_BIT;
                     bit_d      = 4'h0;
                     sda_oe_n_d = slot_oe_n(4'h0, shf_q, rd_byte, rem_q == 8'h01);
                  end
               endcase
         ST_BIT:
         begin
            if (tick)
               unique case (qtr_q)
                  2'h0: scl_oe_n_d = 1'b1;    // data set up, clock rises
                  2'h1:
                  begin
                     // sample in mid high phase, far from either edge
                     if (bit_q != ACK_SLOT)
                        shf_d = {shf_q[6:0], sda_s_q};
                     else
                        ack_ok_d = !sda_s_q;
                  end
                  2'h2: scl_oe_n_d = 1'b0;    // clock falls, data may now change
                  2'h3:
                  begin
                     if (bit_q != ACK_SLOT)
                     begin
                        bit_d      = bit_q + 4'h1;
                        sda_oe_n_d = slot_oe_n(bit_q + 4'h1, shf_q, rd_byte,
                                               rem_q == 8'h01);
                     end
                     else if (!rd_byte && !ack_ok_q)
                     begin
                        // refused byte: stop, the next request starts afresh
                        nack_d     = 1'b1;
                        state_d    = ST_STOP;
                        sda_oe_n_d = 1'b0;
                     end
                     else
                     begin
                        bit_d = 4'h0;
                        unique case (stg_q)
                           STG_ADDR_WR:
                           begin
                              stg_d = STG_CODE;
                              shf_d = cmd_code_q;
                           end
                           STG_CODE, STG_PARAM:
                           begin
                              if (stg_q == STG_CODE && hasp_q)
                              begin
                                 stg_d = STG_PARAM;
                                 shf_d = par_q;
                              end
                              else if (rdaft_q)
                              begin
                                 // read back one byte to confirm the command
                                 stg_d   = STG_ADDR_RD;
                                 shf_d   = addr_byte(sel_q, DIR_READ);
                                 state_d = ST_START;
                              end
                              else
                                 state_d = ST_STOP;
                           end
                           STG_ADDR_RD: stg_d = STG_READ;
                           default:
                           begin
                              // read byte: same register every time
                              data_d = shf_q;
                              rem_d  = rem_q - 8'h01;
                              if (rem_q == 8'h01)
                                 state_d = ST_STOP;
                           end
                        endcase
                        if (state_d == ST_STOP)
                           sda_oe_n_d = 1'b0;  // data low ready for STOP
                        else if (state_d == ST_START)
                           sda_oe_n_d = 1'b1;  // release before repeated START
                        else
                           sda_oe_n_d = slot_oe_n(4'h0, shf_d, stg_d == STG_READ,
                                                  rem_d == 8'h01);
                     end
                  end
               endcase
         end
         ST_STOP:
            if (tick)
               unique case (qtr_q)
                  2'h0: scl_oe_n_d = 1'b1;    // clock high, data held low
                  2'h1: sda_oe_n_d = 1'b1;    // data rises while clock high
                  2'h2: ;                     // bus free time
                  2'h3:
                  begin
                     state_d     = ST_IDLE;
                     ready_d     = 1'b1;
                     busy_d      = 1'b0;
                     rsp_valid_d = 1'b1;
                  end
               endcase
      endcase
   end

   // registers of the sequencer; drive values stay low since open drain only pulls down
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q <= ST_IDLE;
         {qtr_q, tmr_q, bit_q, shf_q, stg_q, rem_q, par_q, cmd_code_q, hasp_q, rdaft_q, fast_q,
          sel_q, ack_ok_q, busy_q, nack_q, data_q, rsp_valid_q, drive_low_q} <= '0;
         {scl_oe_n_q, sda_oe_n_q, ready_q} <= 3'h7;  // lines released, port ready
      end
      else
      begin
         state_q     <= state_d;
         {qtr_q, tmr_q, bit_q, shf_q, stg_q, rem_q, par_q, cmd_code_q, hasp_q, rdaft_q, fast_q,
          sel_q, ack_ok_q, scl_oe_n_q, sda_oe_n_q, ready_q, busy_q, nack_q, data_q} <=
            {qtr_d, tmr_d, bit_d, shf_d, stg_d, rem_d, par_d, cmd_code_d, hasp_d, rdaft_d, fast_d,
             sel_d, ack_ok_d, scl_oe_n_d, sda_oe_n_d, ready_d, busy_d, nack_d, data_d};
         rsp_valid_q <= rsp_valid_d;
         drive_low_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign cmd_ready = ready_q;
   assign rsp_valid = rsp_valid_q;
   assign rsp_nack  = nack_q;
   assign rsp_data  = data_q;
   assign busy      = busy_q;
   assign scl_out   = drive_low_q;
   assign scl_oe_n  = scl_oe_n_q;
   assign sda_out   = drive_low_q;
   assign sda_oe_n  = sda_oe_n_q;

endmodule : i2h_master

/* i2h_pkg.sv */
package i2h_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_PERIOD_NS = 8;        // sys_clk period
   localparam int QTR_STD_NS    = 2500;     // quarter bit at 100 kbit/s
   localparam int QTR_FAST_NS   = 625;      // quarter bit at 400 kbit/s
   // least times, rounded up to whole clocks
   localparam logic [8:0] QTR_STD_CYC  = 9'((QTR_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [8:0] QTR_FAST_CYC = 9'((QTR_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   ////////////////////////////////////////////////////////////////////////////////
   // addressing
   localparam logic [4:0] DEV_ADDR_UPPER = 5'h03; // fixed upper address bits, plain default
   localparam logic       DIR_WRITE      = 1'b0;  // direction bit for master writes
   localparam logic       DIR_READ       = 1'b1;  // direction bit for master reads

   ////////////////////////////////////////////////////////////////////////////////
   // command codes
   localparam logic [7:0] CMD_DEVICE_RESET   = 8'hF0;
   localparam logic [7:0] CMD_CONFIG_WRITE   = 8'hD2;
   localparam logic [7:0] CMD_POINTER_SELECT = 8'hE1;
   localparam logic [7:0] CMD_LINE_RESET     = 8'hB4;
   localparam logic [7:0] CMD_LINE_WRITE     = 8'hA5;
   localparam logic [7:0] CMD_LINE_READ      = 8'h96;
   localparam logic [7:0] CMD_LINE_SINGLE    = 8'h87;
   localparam logic [7:0] CMD_LINE_TRIPLET   = 8'h78;
   localparam logic [7:0] PTR_CONFIG         = 8'hC3;

   ////////////////////////////////////////////////////////////////////////////////
   // byte stages within a transfer
   localparam logic [2:0] STG_ADDR_WR = 3'h0;
   localparam logic [2:0] STG_CODE    = 3'h1;
   localparam logic [2:0] STG_PARAM   = 3'h2;
   localparam logic [2:0] STG_ADDR_RD = 3'h3;
   localparam logic [2:0] STG_READ    = 3'h4;
   localparam logic [3:0] ACK_SLOT    = 4'h8;  // ninth slot of a byte

   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BIT, ST_STOP} i2h_state_type;

endpackage : i2h_pkg

/* i2h_master_chk.sv */
`timescale 1ns/1ps
module i2h_master_chk
   import i2h_pkg::*;
(
   input wire logic       sys_clk,       // system clock
   input wire logic       resetn,        // async reset, active low
   input wire logic       fast_mode,     // rate select
   input wire logic [1:0] dev_addr_sel,  // strapped low address bits
   input wire logic       cmd_valid,     // request
   input wire logic       cmd_ready,     // idle
   input wire logic       cmd_is_read,   // read-only transfer
   input wire logic [7:0] cmd_code,      // command byte
   input wire logic       cmd_has_param, // parameter follows
   input wire logic [7:0] cmd_param,     // parameter byte
   input wire logic       cmd_rd_after,  // read-back after write
   input wire logic [7:0] cmd_rd_len,    // read length
   input wire logic       rsp_valid,     // end pulse
   input wire logic       rsp_nack,      // refusal seen
   input wire logic [7:0] rsp_data,      // last byte read
   input wire logic       busy,          // transfer running
   input wire logic       scl_in,        // clock wire
   input wire logic       scl_out,       // clock drive value
   input wire logic       scl_oe_n,      // clock pull, active low
   input wire logic       sda_in,        // data wire
   input wire logic       sda_out,       // data drive value
   input wire logic       sda_oe_n       // data pull, active low
);
   logic [1:0] idle_q; // edges with both lines high, saturating
   logic [1:0] idle_d; // next count

   ////////////////////////////////////////////////////////////////////////////////
   // count idle edges; the design's two-flop sync needs them before a take
   always_comb idle_d = (scl_in && sda_in) ? ((idle_q == 2'h3) ? idle_q : idle_q + 2'h1) : 2'h0;
   always_ff @(posedge sys_clk or negedge resetn)
      if (!resetn) idle_q <= 2'h0;
      else         idle_q <= idle_d;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   ////////////////////////////////////////////////////////////////////////////////
   // a data fall under a high clock is a start: clock must follow within a quarter
   property p_start_shape;
      $fell(sda_oe_n) && scl_oe_n && $past(scl_oe_n) |-> (!sda_oe_n) throughout (##[1:330] !scl_oe_n);
   endproperty
   a_start_shape: assert property (p_start_shape) else $error("start not followed by clock low");
   // a data rise under a high clock is a stop: the transfer ends two quarters later
   property p_stop_done;
      $rose(sda_oe_n) && scl_oe_n && $past(scl_oe_n) |-> ##[1:700] rsp_valid;
   endproperty
   a_stop_done: assert property (p_stop_done) else $error("stop without end pulse");
   property p_idle_released;
      !busy |-> scl_oe_n && sda_oe_n;
   endproperty
   a_idle_released: assert property (p_idle_released) else $error("line held while idle");
   property p_take;
      cmd_valid && cmd_ready && idle_q == 2'h3 |=> !cmd_ready && busy;
   endproperty
   a_take: assert property (p_take) else $error("request on idle bus not taken");
   property p_first_start;
      $fell(cmd_ready) |-> busy ##[1:1000] ($fell(sda_oe_n) && scl_oe_n);
   endproperty
   a_first_start: assert property (p_first_start) else $error("no start after take");
   property p_end_pulse;
      rsp_valid |-> cmd_ready && !busy ##1 !rsp_valid;
   endproperty
   a_end_pulse: assert property (p_end_pulse) else $error("end pulse malformed");
   property p_result_held;
      cmd_ready && $past(cmd_ready) && !$past(rsp_valid) |-> $stable(rsp_nack) && $stable(rsp_data);
   endproperty
   a_result_held: assert property (p_result_held) else $error("result changed while idle");
   // open-drain: the drive value never goes high, only the enable moves
   property p_open_drain;
      1'b1 |-> !scl_out && !sda_out;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("line driven high");

   c_nack:  cover property (rsp_valid && rsp_nack);
   c_ok:    cover property (rsp_valid && !rsp_nack);
   c_slow:  cover property ($fell(cmd_ready) && !fast_mode);
endmodule : i2h_master_chk

bind i2h_master i2h_master_chk i2h_master_chk_inst (
   .sys_clk(sys_clk), .resetn(resetn), .fast_mode(fast_mode), .dev_addr_sel(dev_addr_sel),
   .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_is_read(cmd_is_read),
   .cmd_code(cmd_code), .cmd_has_param(cmd_has_param), .cmd_param(cmd_param),
   .cmd_rd_after(cmd_rd_after), .cmd_rd_len(cmd_rd_len), .rsp_valid(rsp_valid),
   .rsp_nack(rsp_nack), .rsp_data(rsp_data), .busy(busy), .scl_in(scl_in),
   .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe_n(sda_oe_n));

/* i2h_dev_model.sv */
`timescale 1ns/1ps
module i2h_dev_model
   import i2h_pkg::*;
(
   input  wire logic scl,                 // clock wire
   input  wire logic sda,                 // data wire
   input  wire logic addr_strap_pin_low,  // strap for slave_addr_bit_low
   input  wire logic addr_strap_pin_high, // strap for slave_addr_bit_high
   input  wire logic line_busy,           // line engine busy flag
   output logic      sda_oe_n             // low while pulling data low
);
   logic [7:0] sh, cmd, cfg, rd_byte; // shifter, command, config, outgoing byte
   logic [2:0] stg;                   // byte stage; 3'h5 surplus, 3'h7 ignoring
   logic [3:0] bcnt;                  // bits done; 4'hF before the first bit
   logic       ptr_cfg, mack, ok;     // pointer at config, master ack, our ack

   initial begin
      sda_oe_n = 1'b1;
      stg      = 3'h7;
      bcnt     = 4'hF;
      cfg      = 8'h00;
      ptr_cfg  = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // start and repeated start restart addressing; stop goes quiet
   always @(negedge sda) if (scl === 1'b1) begin stg = STG_ADDR_WR; bcnt = 4'hF; end
   always @(posedge sda) if (scl === 1'b1) stg = 3'h7;
   // capture on the rising clock edge, rate independent
   always @(posedge scl)
      if (bcnt < 4'h8) sh = {sh[6:0], sda};
      else mack = !sda;

   ////////////////////////////////////////////////////////////////////////////////
   // everything we drive changes after a falling clock edge; the line is released
   // first so a stale level never lingers into the next bit
   always @(negedge scl) begin
      sda_oe_n = 1'b1;
      if (stg != 3'h7) begin
         if (bcnt == 4'hF) bcnt = 4'h0;
         else if (bcnt == 4'h7) begin
            bcnt = 4'h8;
            if (stg != STG_READ) ack_byte();
         end
         else if (bcnt == 4'h8) begin
            bcnt = 4'h0;
            if (stg == STG_READ && !mack) stg = 3'h7;
            if (stg == STG_READ) sda_oe_n = rd_byte[7];
         end
         else begin
            bcnt = bcnt + 4'h1;
            if (stg == STG_READ) sda_oe_n = rd_byte[3'h7 - bcnt[2:0]];
         end
      end
   end

   // judge a received byte and pull the ack slot if accepted
   task automatic ack_byte();
      ok = 1'b0;
      case (stg)
         STG_ADDR_WR: begin
            ok = sh[7:1] == {DEV_ADDR_UPPER, addr_strap_pin_high, addr_strap_pin_low};
            stg = sh[0] ? STG_READ : STG_CODE;
            rd_byte = ptr_cfg ? cfg : {7'h00, line_busy}; // status layout is our choice
         end
         STG_CODE: begin
            cmd = sh;
            ok = (sh inside {CMD_DEVICE_RESET, CMD_CONFIG_WRITE, CMD_POINTER_SELECT}) ||
                 (!line_busy && (sh inside {CMD_LINE_RESET, CMD_LINE_WRITE,
                   CMD_LINE_READ, CMD_LINE_SINGLE, CMD_LINE_TRIPLET}));
            if (ok && sh == CMD_DEVICE_RESET) cfg = 8'h00;
            if (ok && sh != CMD_CONFIG_WRITE && sh != CMD_POINTER_SELECT) ptr_cfg = 1'b0;
            stg = (sh inside {CMD_DEVICE_RESET, CMD_LINE_RESET, CMD_LINE_READ}) ? 3'h5 : STG_PARAM;
         end
         STG_PARAM: begin
            ok = cmd != CMD_POINTER_SELECT || sh == PTR_CONFIG;
            if (cmd == CMD_CONFIG_WRITE) cfg = sh;
            if (ok && (cmd == CMD_CONFIG_WRITE || cmd == CMD_POINTER_SELECT)) ptr_cfg = 1'b1;
            stg = 3'h5;
         end
         default: ok = 1'b0; // surplus bytes are never taken
      endcase
      if (!ok) stg = 3'h7;
      sda_oe_n = !ok;
   endtask : ack_byte
endmodule : i2h_dev_model

/* i2h_master_tb.sv */
`timescale 1ns/1ps
module i2h_master_tb;
   import i2h_pkg::*;
   logic       sys_clk, resetn, fast_mode, cmd_valid, cmd_ready, cmd_is_read;
   logic       cmd_has_param, cmd_rd_after, rsp_valid, rsp_nack, busy, line_busy;
   logic       scl_out, scl_oe_n, sda_out, sda_oe_n, dev_oe_n;
   logic [1:0] dev_addr_sel, strap;
   logic [7:0] cmd_code, cmd_param, cmd_rd_len, rsp_data;
   wire        scl_w, sda_w;   // wired-AND lines with pull-ups
   int         error_cnt, checked;

   assign scl_w = scl_oe_n ? 1'b1 : scl_out;
   assign sda_w = (sda_oe_n ? 1'b1 : sda_out) & dev_oe_n;

   i2h_master i2h_master_inst (.sys_clk(sys_clk), .resetn(resetn), .fast_mode(fast_mode),
      .dev_addr_sel(dev_addr_sel), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_is_read(cmd_is_read), .cmd_code(cmd_code), .cmd_has_param(cmd_has_param),
      .cmd_param(cmd_param), .cmd_rd_after(cmd_rd_after), .cmd_rd_len(cmd_rd_len),
      .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_data(rsp_data), .busy(busy),
      .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n));
   i2h_dev_model i2h_dev_model_inst (.scl(scl_w), .sda(sda_w), .addr_strap_pin_low(strap[0]),
      .addr_strap_pin_high(strap[1]), .line_busy(line_busy), .sda_oe_n(dev_oe_n));

   always #4 sys_clk = ~sys_clk;

   ////////////////////////////////////////////////////////////////////////////////
   // compare helpers
   task automatic chk1(input string name, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin error_cnt++; $display("[ERR] %s exp %h got %h", name, exp, got); end
   endtask : chk1
   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin error_cnt++; $display("[ERR] %s exp %h got %h", name, exp, got); end
   endtask : chk8

   // one transfer: hold the request until it is taken, then wait for the end pulse
   task automatic xfer(input logic rd, input logic [7:0] code, input logic hp,
                       input logic [7:0] prm, input logic ra, input logic [7:0] len);
      int n;
      @(posedge sys_clk); #1;
      cmd_is_read = rd; cmd_code = code; cmd_has_param = hp;
      cmd_param = prm; cmd_rd_after = ra; cmd_rd_len = len;
      cmd_valid = 1'b1;
      n = 0;
      while (cmd_ready !== 1'b0 && n < 100) begin @(posedge sys_clk); #1; n++; end
      cmd_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 60000) begin @(posedge sys_clk); #1; n++; end
      chk1("rsp_valid", 1'b1, rsp_valid);
   endtask : xfer

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_cfg_readback();
      xfer(1'b0, CMD_CONFIG_WRITE, 1'b1, 8'h5A, 1'b1, 8'h01);
      chk1("cfg nack", 1'b0, rsp_nack);
      chk8("cfg data", 8'h5A, rsp_data);
   endtask : t_cfg_readback
   task automatic t_ptr_repeat();
      xfer(1'b0, CMD_POINTER_SELECT, 1'b1, PTR_CONFIG, 1'b0, 8'h00);
      chk1("ptr nack", 1'b0, rsp_nack);
      xfer(1'b1, 8'h00, 1'b0, 8'h00, 1'b0, 8'h03);
      chk1("rd nack", 1'b0, rsp_nack);
      chk8("rd data", 8'h5A, rsp_data);
      xfer(1'b0, CMD_POINTER_SELECT, 1'b1, 8'hE5, 1'b0, 8'h00);
      chk1("bad ptr nack", 1'b1, rsp_nack);
   endtask : t_ptr_repeat
   task automatic t_codes();
      logic [7:0] codes [6];
      codes = '{CMD_DEVICE_RESET, CMD_LINE_RESET, CMD_LINE_WRITE,
                CMD_LINE_READ, CMD_LINE_SINGLE, CMD_LINE_TRIPLET};
      foreach (codes[i]) begin
         xfer(1'b0, codes[i], 1'b0, 8'h00, 1'b0, 8'h00);
         chk1("code nack", 1'b0, rsp_nack);
      end
      xfer(1'b0, 8'h55, 1'b0, 8'h00, 1'b0, 8'h00);
      chk1("bad code nack", 1'b1, rsp_nack);
   endtask : t_codes
   task automatic t_busy();
      line_busy = 1'b1;
      xfer(1'b0, CMD_LINE_RESET, 1'b0, 8'h00, 1'b0, 8'h00);
      chk1("busy nack", 1'b1, rsp_nack);
      xfer(1'b0, CMD_DEVICE_RESET, 1'b1, 8'h00, 1'b0, 8'h00);
      chk1("surplus nack", 1'b1, rsp_nack);
      xfer(1'b1, 8'h00, 1'b0, 8'h00, 1'b0, 8'h01);
      chk8("status data", 8'h01, rsp_data);
      line_busy = 1'b0;
   endtask : t_busy
   // slow rate, wrong strap: address refused
   task automatic t_addr_slow();
      fast_mode = 1'b0;
      dev_addr_sel = 2'h1;
      xfer(1'b1, 8'h00, 1'b0, 8'h00, 1'b0, 8'h01);
      chk1("addr nack", 1'b1, rsp_nack);
      fast_mode = 1'b1;
      dev_addr_sel = 2'h2;
   endtask : t_addr_slow

   ////////////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic test_done();
      if (error_cnt == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done

   // watchdog, beyond the expected run of about 130k clocks
   initial begin
      #1400000;
      error_cnt++;
      test_done();
   end

   initial begin
      sys_clk = 1'b0; resetn = 1'b0; fast_mode = 1'b1; dev_addr_sel = 2'h2; strap = 2'h2;
      cmd_valid = 1'b0; cmd_is_read = 1'b0; cmd_code = 8'h00; cmd_has_param = 1'b0;
      cmd_param = 8'h00; cmd_rd_after = 1'b0; cmd_rd_len = 8'h00; line_busy = 1'b0;
      error_cnt = 0; checked = 0;
      repeat (10) @(posedge sys_clk);
      #1 resetn = 1'b1;
      t_cfg_readback();
      t_ptr_repeat();
      t_codes();
      t_busy();
      t_addr_slow();
      test_done();
   end
endmodule : i2h_master_tb
